/* File: core/iobe_top.sv */
`timescale 1ns/1ps

// ==========================================================

module iobe_top
    import iobe_pkg::*;
#(
    parameter int unsigned DATA_W = IOBE_DATA_W,
    parameter int unsigned MATCH_W = IOBE_MATCH_W,
    parameter logic [3:0] ADDR_PATTERN = IOBE_PATTERN_DEF
)
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Control inputs from the processor
    input wire logic port_gate_n_i,
    input wire logic addr_phase_flag_i,
    input wire logic write_cmd_i,
    input wire logic bus_strobe_i,
    // Control repeated toward the ports
    output logic port_gate_n_o,
    output logic addr_phase_flag_o,
    output logic write_cmd_o,
    output logic bus_strobe_o,
    // Processor-side bus, index 0 is the MSB
    input wire logic [0:DATA_W-1] cpu_side_bus_i,
    output logic [0:DATA_W-1] cpu_side_bus_o,
    output logic cpu_side_bus_oe_o,
    // Port-side bus
    input wire logic [0:DATA_W-1] port_side_bus_i,
    output logic [0:DATA_W-1] port_side_bus_o,
    output logic port_side_bus_oe_o,
    // Select latch, visible for the system
    output logic selected_o
);

    // ==========================================================
    // Elaboration checks
    generate
        if (DATA_W != IOBE_DATA_W)
        begin : g_bad_data_w
            $error("iobe_top: DATA_W must be 8");
        end
        if (MATCH_W != IOBE_MATCH_W)
        begin : g_bad_match_w
            $error("iobe_top: MATCH_W must be 4");
        end
    endgenerate

    // ==========================================================
    // State
    typedef struct packed {
        logic strobe_prev;
        logic sel;
        logic gate_n;
        logic phase;
        logic write;
        logic strobe;
    } iobe_top_st_t;

    iobe_top_st_t st_ff;
    iobe_top_st_t nxt_st;

    logic strobe_fall;
    logic compare_evt;
    logic addr_match;
    logic to_cpu;

    // ==========================================================
    // Address decode
    always_comb
    begin
        strobe_fall = st_ff.strobe_prev & ~bus_strobe_i;
        // Comparison happens with the gate open in the address phase
        compare_evt = strobe_fall & ~port_gate_n_i & addr_phase_flag_i;
        // Low bus level is a logical one; low four bits are ignored,
        // which gives one device a block of sixteen ports
        addr_match = (~cpu_side_bus_i[0:MATCH_W-1] == ADDR_PATTERN);
        // Unselected expanders never drive the shared processor bus
        to_cpu = ~port_gate_n_i & ~addr_phase_flag_i & ~write_cmd_i;
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_st = st_ff;
        if (ce_i)
        begin
            nxt_st.strobe_prev = bus_strobe_i;
            if (compare_evt)
            begin
                nxt_st.sel = addr_match;
            end
            nxt_st.gate_n = port_gate_n_i;
            nxt_st.phase = addr_phase_flag_i;
            nxt_st.write = write_cmd_i;
            nxt_st.strobe = bus_strobe_i;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_ff.strobe_prev <= IOBE_RST_STROBE;
            st_ff.sel <= IOBE_RST_SEL;
            st_ff.gate_n <= IOBE_RST_GATE_N;
            st_ff.phase <= IOBE_RST_PHASE;
            st_ff.write <= IOBE_RST_WRITE;
            st_ff.strobe <= IOBE_RST_STROBE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign port_gate_n_o = st_ff.gate_n;
    assign addr_phase_flag_o = st_ff.phase;
    assign write_cmd_o = st_ff.write;
    assign bus_strobe_o = st_ff.strobe;
    assign selected_o = st_ff.sel;

    // ==========================================================
    // Data paths
    // Direction follows the current latch, so a new selection takes
    // effect on the cycle after the strobe edge that made it
    iobe_lane #(
        .WIDTH(DATA_W)
    ) u_lane (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .to_cpu_i(to_cpu),
        .cpu_en_i(st_ff.sel),
        .cpu_i(cpu_side_bus_i),
        .cpu_o(cpu_side_bus_o),
        .cpu_oe_o(cpu_side_bus_oe_o),
        .port_i(port_side_bus_i),
        .port_o(port_side_bus_o),
        .port_oe_o(port_side_bus_oe_o)
    );

    // ==========================================================
    // Assertions
    sequence s_strobe_fall;
        ce_i && bus_strobe_i ##1 ce_i && !bus_strobe_i;
    endsequence

    sequence s_compare;
        s_strobe_fall ##0 (!port_gate_n_i && addr_phase_flag_i);
    endsequence

    a_sel_set_match: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_compare ##0 (~cpu_side_bus_i[0:3] == ADDR_PATTERN) |=> selected_o)
        else $error("select latch not set on matching address");

    a_sel_clear_miss: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_compare ##0 (~cpu_side_bus_i[0:3] != ADDR_PATTERN) |=> !selected_o)
        else $error("select latch not cleared on other address");

    a_sel_edge_only: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (!ce_i || bus_strobe_i || !st_ff.strobe_prev || port_gate_n_i
            || !addr_phase_flag_i) |=> $stable(selected_o))
        else $error("select latch changed without a strobe trailing edge");

    a_ctrl_repeat: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !sys_rst_i && ce_i |=> (port_gate_n_o == $past(port_gate_n_i))
            && (addr_phase_flag_o == $past(addr_phase_flag_i))
            && (write_cmd_o == $past(write_cmd_i))
            && (bus_strobe_o == $past(bus_strobe_i)))
        else $error("control outputs do not repeat inputs");

    a_dir_to_cpu: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        // Release edge still has the flops in reset, so skip it
        !sys_rst_i && ce_i && !port_gate_n_i && !addr_phase_flag_i && !write_cmd_i
            && selected_o
        |=> cpu_side_bus_oe_o && !port_side_bus_oe_o
            && (cpu_side_bus_o == $past(port_side_bus_i)))
        else $error("read path toward processor not driven");

    a_dir_to_port: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !sys_rst_i && ce_i && (port_gate_n_i || addr_phase_flag_i || write_cmd_i)
        |=> port_side_bus_oe_o && !cpu_side_bus_oe_o
            && (port_side_bus_o == $past(cpu_side_bus_i)))
        else $error("write path toward ports not driven");

    a_unsel_quiet: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        ce_i && !selected_o |=> !cpu_side_bus_oe_o)
        else $error("unselected expander drives processor bus");

    a_no_contention: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !(cpu_side_bus_oe_o && port_side_bus_oe_o))
        else $error("both sides driven at once");

    a_freeze_hold: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !ce_i |=> $stable(selected_o) && $stable(cpu_side_bus_oe_o)
            && $stable(port_side_bus_oe_o) && $stable(bus_strobe_o))
        else $error("state moved while clock enable low");

    a_sel_to_drive: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_compare ##0 (~cpu_side_bus_i[0:3] == ADDR_PATTERN)
        ##1 (ce_i && !port_gate_n_i && !addr_phase_flag_i && !write_cmd_i)
        |=> cpu_side_bus_oe_o)
        else $error("selected expander failed to answer a read");

endmodule

/* File: inc/iobe_pkg.sv */
package iobe_pkg;

    // ==========================================================
    // Bus geometry
    localparam int unsigned IOBE_DATA_W = 8;
    localparam int unsigned IOBE_MATCH_W = 4;
    localparam int unsigned IOBE_BLOCK_PORTS = 16;

    // ==========================================================
    // Manufactured address pattern, logical (active high) value
    localparam logic [3:0] IOBE_PATTERN_DEF = 4'h1;

    // ==========================================================
    // Values after reset
    localparam logic IOBE_RST_SEL = 1'b0;
    localparam logic IOBE_RST_GATE_N = 1'b1;
    localparam logic IOBE_RST_PHASE = 1'b0;
    localparam logic IOBE_RST_WRITE = 1'b0;
    localparam logic IOBE_RST_STROBE = 1'b0;
    localparam logic IOBE_RST_OE = 1'b0;
    localparam logic [7:0] IOBE_RST_DATA = 8'h00;

    // ==========================================================
    // Pipeline depth from pin to repeated pin, in clock cycles
    localparam int unsigned IOBE_PASS_CYCLES = 1;

endpackage

/* File: core/iobe_lane.sv */
`timescale 1ns/1ps

// Registered two-way lane: at most one direction drives, the other listens
module iobe_lane
    import iobe_pkg::*;
#(
    parameter int unsigned WIDTH = IOBE_DATA_W
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Direction, high toward the processor side
    input wire logic to_cpu_i,
    input wire logic cpu_en_i,
    // Processor side
    input wire logic [WIDTH-1:0] cpu_i,
    output logic [WIDTH-1:0] cpu_o,
    output logic cpu_oe_o,
    // Port side
    input wire logic [WIDTH-1:0] port_i,
    output logic [WIDTH-1:0] port_o,
    output logic port_oe_o
);

    // ==========================================================
    // Elaboration check
    generate
        if (WIDTH == 0 || WIDTH > IOBE_DATA_W)
        begin : g_bad_width
            $error("iobe_lane: WIDTH out of range");
        end
    endgenerate

    // ==========================================================
    // State
    typedef struct packed {
        logic [WIDTH-1:0] cpu;
        logic cpu_oe;
        logic [WIDTH-1:0] port;
        logic port_oe;
    } iobe_lane_st_t;

    iobe_lane_st_t st_ff;
    iobe_lane_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (ce_i)
        begin
            // Non-inverting copy in both directions
            nxt_st.cpu = port_i;
            nxt_st.port = cpu_i;
            // Never both drivers on, so no fight through the buffer
            nxt_st.cpu_oe = to_cpu_i & cpu_en_i;
            nxt_st.port_oe = ~to_cpu_i;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_ff.cpu <= WIDTH'(IOBE_RST_DATA);
            st_ff.cpu_oe <= IOBE_RST_OE;
            st_ff.port <= WIDTH'(IOBE_RST_DATA);
            st_ff.port_oe <= IOBE_RST_OE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cpu_o = st_ff.cpu;
    assign cpu_oe_o = st_ff.cpu_oe;
    assign port_o = st_ff.port;
    assign port_oe_o = st_ff.port_oe;

endmodule

/* File: verification/iobe_cpu_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Processor side of the expander: resolves the shared bus
module iobe_cpu_model
    import iobe_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Processor drive request
    input wire logic drive_i,
    input wire logic [0:7] value_i,
    // Expander side of the bus
    input wire logic [0:7] dut_data_i,
    input wire logic dut_oe_i,
    output logic [0:7] bus_o
);
    logic [0:7] last_ff = 8'h00;

    // Released bus toggles each cycle, so a stale value never passes
    always_comb
    begin
        if (dut_oe_i)
            bus_o = dut_data_i;
        else if (drive_i)
            bus_o = value_i;
        else
            bus_o = ~last_ff;
    end

    always_ff @(posedge clock_i)
    begin
        last_ff <= bus_o;
    end
endmodule

/* File: verification/iobe_top_bench.sv */
`timescale 1ns/1ps

module iobe_top_bench
    import iobe_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    localparam logic [3:0] PAT = 4'h3;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic gate_n = 1'b1, phase = 1'b0, wr = 1'b0, strobe = 1'b0, drive = 1'b1;
    logic ce = 1'b1;
    logic [0:7] cpu_val = 8'h00, port_in = 8'h00, cpu_bus, cpu_o, port_o;
    logic cpu_oe, port_oe, sel;
    logic [3:0] ctl_o;
    int fails = 0;
    int tests_run = 0;

    always #10 clock_i = ~clock_i;

    iobe_top #(.ADDR_PATTERN(PAT)) dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .port_gate_n_i(gate_n), .addr_phase_flag_i(phase), .write_cmd_i(wr),
        .bus_strobe_i(strobe), .port_gate_n_o(ctl_o[3]), .addr_phase_flag_o(ctl_o[2]),
        .write_cmd_o(ctl_o[1]), .bus_strobe_o(ctl_o[0]), .cpu_side_bus_i(cpu_bus),
        .cpu_side_bus_o(cpu_o), .cpu_side_bus_oe_o(cpu_oe), .port_side_bus_i(port_in),
        .port_side_bus_o(port_o), .port_side_bus_oe_o(port_oe), .selected_o(sel));

    iobe_cpu_model cpu (.clock_i(clock_i), .drive_i(drive), .value_i(cpu_val),
        .dut_data_i(cpu_o), .dut_oe_i(cpu_oe), .bus_o(cpu_bus));

    // ==========================================================
    // Shared helpers
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_byte({7'h00, got}, {7'h00, exp}, msg);
    endtask

    // Control code is {gate_n, phase, write, strobe}; processor idles on reads
    task automatic put(input logic [3:0] c, input logic [7:0] cv, input logic [7:0] pv);
        @(posedge clock_i);
        {gate_n, phase, wr, strobe} <= c;
        drive <= |c[3:1];
        cpu_val <= cv;
        port_in <= pv;
    endtask

    task automatic settle();
        @(posedge clock_i);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        chk_byte({ctl_o, cpu_oe, port_oe, 1'b0, sel}, 8'h80, "reset state");
        $display("test reset done");
    endtask

    task automatic t_repeat();
        for (int c = 0; c < 16; c++)
        begin
            put(c[3:0], 8'hFF, 8'h00);
            settle();
            chk_byte({4'h0, ctl_o}, {4'h0, c[3:0]}, "control repeat");
        end
        $display("test control repeat done");
    endtask

    task automatic t_compare();
        logic [7:0] a;
        for (int u = 0; u < 16; u++)
        begin
            a = ~{u[3:0], u[3:0] ^ 4'hA};
            put(4'b0101, a, 8'h00);
            put(4'b0100, a, 8'h00);
            settle();
            chk_bit(sel, u[3:0] == PAT, "address compare");
        end
        a = ~{PAT, 4'h0};
        put(4'b0101, a, 8'h00);
        repeat (3) settle();
        chk_bit(sel, 1'b0, "latched before strobe fall");
        put(4'b0100, a, 8'h00);
        settle();
        chk_bit(sel, 1'b1, "compare at strobe fall");
        put(4'b1101, 8'h00, 8'h00);
        put(4'b1100, 8'h00, 8'h00);
        settle();
        chk_bit(sel, 1'b1, "fall with gate high");
        put(4'b0001, 8'h00, 8'h00);
        put(4'b0000, 8'h00, 8'h00);
        settle();
        chk_bit(sel, 1'b1, "fall outside address phase");
        $display("test address compare done");
    endtask

    task automatic t_direction(input logic s);
        logic [7:0] a;
        logic rd;
        a = ~{s ? PAT : ~PAT, 4'h5};
        put(4'b0101, a, 8'h00);
        put(4'b0100, a, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            rd = (c == 0);
            put({c[2:0], 1'b0}, 8'hC3 ^ c[7:0], 8'h5A ^ c[7:0]);
            // Registered read driver lets go one edge late, so wait it out
            repeat (2) settle();
            chk_bit(sel, s, "select latch");
            chk_byte({6'h00, cpu_oe, port_oe}, {6'h00, rd & s, ~rd}, "direction");
            if (rd & s)
                chk_byte(cpu_o, 8'h5A ^ c[7:0], "port to processor");
            if (!rd)
                chk_byte(port_o, 8'hC3 ^ c[7:0], "processor to port");
        end
        $display("test direction done");
    endtask

    // Strobe fall with a matching address while frozen must not land
    task automatic t_freeze();
        put(4'b0101, ~{PAT, 4'h0}, 8'h00);
        @(posedge clock_i);
        ce <= 1'b0;
        {gate_n, phase, wr, strobe} <= 4'b0100;
        repeat (4) settle();
        chk_byte({ctl_o, cpu_oe, port_oe, 1'b0, sel}, 8'h54, "frozen state");
        @(posedge clock_i);
        ce <= 1'b1;
        settle();
        chk_bit(sel, 1'b1, "compare after freeze");
        chk_byte({4'h0, ctl_o}, 8'h04, "repeat after freeze");
        $display("test clock enable done");
    endtask

    // ==========================================================
    // Verdict
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        t_reset();
        t_repeat();
        t_compare();
        t_direction(1'b1);
        t_direction(1'b0);
        t_freeze();
        complete_run();
    end
endmodule
